// file: verilog/feo_defines.vh
// Offsets, field positions, reset values and widths of the fundamental energy status bank.
// Assumes byte addressing on the host register port, with multi-byte registers stored least significant byte first.
`ifndef FEO_DEFINES_VH
`define FEO_DEFINES_VH

// ----------------------------------------------------------------
// Host register port
// ----------------------------------------------------------------
`define FEO_ADDR_W 10
`define FEO_AUX_RMS_OFS 10'h11c
`define FEO_FLAGS_A_OFS 10'h147
`define FEO_FLAGS_B_OFS 10'h233
`define FEO_FLAGS_C_OFS 10'h31f
`define FEO_ENERGY_A_OFS 10'h1fc
`define FEO_ENERGY_B_OFS 10'h2e8
`define FEO_ENERGY_C_OFS 10'h3d4
`define FEO_UNMAPPED_DATA 8'h00

// ----------------------------------------------------------------
// Overflow flag fields
// ----------------------------------------------------------------
`define FEO_APPARENT_BIT 4
`define FEO_REACT_NEG_BIT 3
`define FEO_REACT_POS_BIT 2
`define FEO_REAL_NEG_BIT 1
`define FEO_REAL_POS_BIT 0
`define FEO_FLAGS_IMPL_MASK 8'h1f
`define FEO_FLAGS_RESET 8'h00

// ----------------------------------------------------------------
// Energy accumulator and results
// ----------------------------------------------------------------
`define FEO_ENERGY_W 28
`define FEO_WRAP_MODULUS 29'h10000000
`define FEO_ENERGY_RESET 28'h0000000
`define FEO_AUX_RMS_RESET 32'h00000000
`define FEO_AUX_SEL_NEUTRAL 4'h0

// ----------------------------------------------------------------
// Low range linearity correction
// ----------------------------------------------------------------
`define FEO_GAIN_FRAC_BITS 14
`define FEO_LOW_RANGE_PGA_GAIN 32

`endif

// file: verilog/feo_lin_corr.v
// Low range linearity correction for one phase current channel.
// Assumes rms, gain and offset are stable in the cycle in_valid is high, all on ref_clk.
`include "feo_defines.vh"

module feo_lin_corr #(
  parameter RMS_W = 32,
  parameter COEF_W = 16
) (
  input wire ref_clk,
  input wire reset,
  input wire in_valid,
  input wire low_range,
  input wire [RMS_W-1:0] rms,
  input wire [COEF_W-1:0] gain,
  input wire [COEF_W-1:0] offset,
  output reg [RMS_W-1:0] corrected,
  output reg out_valid
);

  localparam SUM_W = RMS_W + 2;
  localparam PROD_W = SUM_W + COEF_W;

  wire signed [SUM_W-1:0] rms_ext = $signed({2'b00, rms});
  wire signed [SUM_W-1:0] ofs_ext = {{(SUM_W-COEF_W){offset[COEF_W-1]}}, offset};
  wire signed [SUM_W-1:0] sum = rms_ext + ofs_ext;
  // A negative corrected sum means no current; clamp rather than wrap to a huge value.
  wire [SUM_W-1:0] sum_pos = sum[SUM_W-1] ? {SUM_W{1'b0}} : sum;
  wire [PROD_W-1:0] prod = sum_pos * {{SUM_W{1'b0}}, gain};
  wire [PROD_W-1:0] scaled = prod >> `FEO_GAIN_FRAC_BITS;
  wire over = |scaled[PROD_W-1:RMS_W];
  reg [RMS_W-1:0] next_corrected;

  always @*
  begin
    next_corrected = rms;
    if (low_range)
    begin
      // Gain of 32 range only; unity range passes through. [RULE14]
      next_corrected = over ? {RMS_W{1'b1}} : scaled[RMS_W-1:0]; // [RULE1]
    end
  end

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      corrected <= {RMS_W{1'b0}};
      out_valid <= 1'b0;
    end
    else
    begin
      out_valid <= in_valid;
      if (in_valid)
        corrected <= next_corrected;
    end
  end

endmodule

// file: verilog/feo_status_regs.v
// Fundamental energy status bank: aux RMS result, per phase overflow flags, real positive energy.
// Assumes all DSP side inputs are on ref_clk and the host port is already decoded to byte accesses.
//
// Operation
// [RULE1] Low range current equals low gain times (rms plus signed offset) over 2^14.
// [RULE2] Aux channel RMS lands in a 32-bit read-only four byte register.
// [RULE3] Aux source select picks neutral current or a chosen harmonic RMS.
// [RULE4] Each phase A, B, C has its own 8-bit overflow flag register.
// [RULE5] A flag sets when its fundamental accumulator overflows; not an error.
// [RULE6] Flags stay set; only the host clears them.
// [RULE7] Bit 4 flags apparent fundamental energy overflow.
// [RULE8] Bit 3 flags reactive negative fundamental energy overflow.
// [RULE9] Bit 2 flags reactive positive fundamental energy overflow.
// [RULE10] Bit 1 flags real negative fundamental energy overflow.
// [RULE11] Bit 0 flags real positive overflow; bits 7 to 5 reserved.
// [RULE12] All flag bits read zero after reset.
// [RULE13] Host adds the wrap modulus to a reading difference after a wrap.
// [RULE14] Low range correction applies only in the gain of 32 range.
// [RULE15] Writing zero clears a flag bit; writing one leaves it unchanged.
`include "feo_defines.vh"

module feo_status_regs #(
  parameter RMS_W = 32,
  parameter COEF_W = 16,
  parameter INC_W = 16
) (
  input wire ref_clk,
  input wire reset,
  // Host register port.
  input wire [`FEO_ADDR_W-1:0] host_addr,
  input wire host_wr,
  input wire [7:0] host_wdata,
  input wire host_rd,
  output reg [7:0] host_rdata,
  output reg host_rvalid,
  // Aux channel results from the DSP core.
  input wire [3:0] aux_source_select,
  input wire aux_rms_valid,
  input wire [31:0] neutral_rms,
  input wire [31:0] harmonic_rms,
  // Fundamental energy events from the DSP core.
  input wire energy_strobe,
  input wire [INC_W-1:0] real_pos_incr_a,
  input wire [INC_W-1:0] real_pos_incr_b,
  input wire [INC_W-1:0] real_pos_incr_c,
  input wire [3:0] wrap_event_a,
  input wire [3:0] wrap_event_b,
  input wire [3:0] wrap_event_c,
  // Phase current linearity correction.
  input wire rms_valid,
  input wire low_range_a,
  input wire low_range_b,
  input wire low_range_c,
  input wire [RMS_W-1:0] phase_current_rms_a,
  input wire [RMS_W-1:0] phase_current_rms_b,
  input wire [RMS_W-1:0] phase_current_rms_c,
  input wire [COEF_W-1:0] low_range_gain_coeff_a,
  input wire [COEF_W-1:0] low_range_gain_coeff_b,
  input wire [COEF_W-1:0] low_range_gain_coeff_c,
  input wire [COEF_W-1:0] low_range_offset_a,
  input wire [COEF_W-1:0] low_range_offset_b,
  input wire [COEF_W-1:0] low_range_offset_c,
  output wire [RMS_W-1:0] corrected_current_a,
  output wire [RMS_W-1:0] corrected_current_b,
  output wire [RMS_W-1:0] corrected_current_c,
  output wire corrected_valid_a,
  output wire corrected_valid_b,
  output wire corrected_valid_c
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function in_word;
    input [`FEO_ADDR_W-1:0] addr;
    input [`FEO_ADDR_W-1:0] base;
    begin
      in_word = (addr[`FEO_ADDR_W-1:2] == base[`FEO_ADDR_W-1:2]);
    end
  endfunction

  function [7:0] word_byte;
    input [31:0] word;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: word_byte = word[7:0];
        2'h1: word_byte = word[15:8];
        2'h2: word_byte = word[23:16];
        default: word_byte = word[31:24];
      endcase
    end
  endfunction

  // Adds one increment and reports a pass through the wrap modulus.
  function [`FEO_ENERGY_W:0] accumulate;
    input [`FEO_ENERGY_W-1:0] energy;
    input [INC_W-1:0] incr;
    reg [`FEO_ENERGY_W:0] sum;
    begin
      sum = {1'b0, energy} + {{(`FEO_ENERGY_W+1-INC_W){1'b0}}, incr};
      if (sum >= `FEO_WRAP_MODULUS)
        accumulate = {1'b1, sum[`FEO_ENERGY_W-1:0]};
      else
        accumulate = sum;
    end
  endfunction

  // Set wins over a host clear in the same cycle; only implemented bits can hold a one.
  function [7:0] next_flags_of;
    input [7:0] flags;
    input [7:0] set;
    input clr_wr;
    input [7:0] wdata;
    reg [7:0] keep;
    begin
      keep = clr_wr ? (flags & wdata) : flags; // [RULE15]
      next_flags_of = (keep | set) & `FEO_FLAGS_IMPL_MASK; // [RULE6] [RULE11]
    end
  endfunction

  // ----------------------------------------------------------------
  // Aux channel RMS result
  // ----------------------------------------------------------------
  reg [31:0] aux_rms_result;

  always @(posedge ref_clk)
  begin
    if (reset)
      aux_rms_result <= `FEO_AUX_RMS_RESET;
    else if (aux_rms_valid)
    begin
      if (aux_source_select == `FEO_AUX_SEL_NEUTRAL)
        aux_rms_result <= neutral_rms; // [RULE3]
      else
        aux_rms_result <= harmonic_rms; // [RULE3]
    end
  end

  // ----------------------------------------------------------------
  // Real positive fundamental energy accumulators
  // ----------------------------------------------------------------
  reg [`FEO_ENERGY_W-1:0] energy_a;
  reg [`FEO_ENERGY_W-1:0] energy_b;
  reg [`FEO_ENERGY_W-1:0] energy_c;
  wire [`FEO_ENERGY_W:0] acc_a = accumulate(energy_a, real_pos_incr_a);
  wire [`FEO_ENERGY_W:0] acc_b = accumulate(energy_b, real_pos_incr_b);
  wire [`FEO_ENERGY_W:0] acc_c = accumulate(energy_c, real_pos_incr_c);

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      energy_a <= `FEO_ENERGY_RESET;
      energy_b <= `FEO_ENERGY_RESET;
      energy_c <= `FEO_ENERGY_RESET;
    end
    else if (energy_strobe)
    begin
      energy_a <= acc_a[`FEO_ENERGY_W-1:0];
      energy_b <= acc_b[`FEO_ENERGY_W-1:0];
      energy_c <= acc_c[`FEO_ENERGY_W-1:0];
    end
  end

  // The accumulator counts modulo the wrap modulus, so upper bits always read zero.
  wire [31:0] energy_word_a = {{(32-`FEO_ENERGY_W){1'b0}}, energy_a};
  wire [31:0] energy_word_b = {{(32-`FEO_ENERGY_W){1'b0}}, energy_b};
  wire [31:0] energy_word_c = {{(32-`FEO_ENERGY_W){1'b0}}, energy_c};

  // ----------------------------------------------------------------
  // Overflow flags
  // ----------------------------------------------------------------
  reg [7:0] flags_a;
  reg [7:0] flags_b;
  reg [7:0] flags_c;
  reg [7:0] set_a;
  reg [7:0] set_b;
  reg [7:0] set_c;

  always @*
  begin
    set_a = 8'h00;
    set_b = 8'h00;
    set_c = 8'h00;
    set_a[`FEO_APPARENT_BIT] = wrap_event_a[3]; // [RULE7]
    set_b[`FEO_APPARENT_BIT] = wrap_event_b[3]; // [RULE7]
    set_c[`FEO_APPARENT_BIT] = wrap_event_c[3]; // [RULE7]
    set_a[`FEO_REACT_NEG_BIT] = wrap_event_a[2]; // [RULE8]
    set_b[`FEO_REACT_NEG_BIT] = wrap_event_b[2]; // [RULE8]
    set_c[`FEO_REACT_NEG_BIT] = wrap_event_c[2]; // [RULE8]
    set_a[`FEO_REACT_POS_BIT] = wrap_event_a[1]; // [RULE9]
    set_b[`FEO_REACT_POS_BIT] = wrap_event_b[1]; // [RULE9]
    set_c[`FEO_REACT_POS_BIT] = wrap_event_c[1]; // [RULE9]
    set_a[`FEO_REAL_NEG_BIT] = wrap_event_a[0]; // [RULE10]
    set_b[`FEO_REAL_NEG_BIT] = wrap_event_b[0]; // [RULE10]
    set_c[`FEO_REAL_NEG_BIT] = wrap_event_c[0]; // [RULE10]
    set_a[`FEO_REAL_POS_BIT] = energy_strobe & acc_a[`FEO_ENERGY_W]; // [RULE5] [RULE11]
    set_b[`FEO_REAL_POS_BIT] = energy_strobe & acc_b[`FEO_ENERGY_W]; // [RULE5] [RULE11]
    set_c[`FEO_REAL_POS_BIT] = energy_strobe & acc_c[`FEO_ENERGY_W]; // [RULE5] [RULE11]
  end

  wire wr_flags_a = host_wr & (host_addr == `FEO_FLAGS_A_OFS); // [RULE4]
  wire wr_flags_b = host_wr & (host_addr == `FEO_FLAGS_B_OFS); // [RULE4]
  wire wr_flags_c = host_wr & (host_addr == `FEO_FLAGS_C_OFS); // [RULE4]

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      flags_a <= `FEO_FLAGS_RESET; // [RULE12]
      flags_b <= `FEO_FLAGS_RESET; // [RULE12]
      flags_c <= `FEO_FLAGS_RESET; // [RULE12]
    end
    else
    begin
      flags_a <= next_flags_of(flags_a, set_a, wr_flags_a, host_wdata); // [RULE5] [RULE6]
      flags_b <= next_flags_of(flags_b, set_b, wr_flags_b, host_wdata); // [RULE5] [RULE6]
      flags_c <= next_flags_of(flags_c, set_c, wr_flags_c, host_wdata); // [RULE5] [RULE6]
    end
  end

  // ----------------------------------------------------------------
  // Host read path
  // ----------------------------------------------------------------
  // Multi-byte reads are not snapshotted; the host should read energy bytes between strobes.
  reg [7:0] next_rdata;

  always @*
  begin
    next_rdata = `FEO_UNMAPPED_DATA;
    if (in_word(host_addr, `FEO_AUX_RMS_OFS))
      next_rdata = word_byte(aux_rms_result, host_addr[1:0]); // [RULE2]
    else if (in_word(host_addr, `FEO_ENERGY_A_OFS))
      next_rdata = word_byte(energy_word_a, host_addr[1:0]);
    else if (in_word(host_addr, `FEO_ENERGY_B_OFS))
      next_rdata = word_byte(energy_word_b, host_addr[1:0]);
    else if (in_word(host_addr, `FEO_ENERGY_C_OFS))
      next_rdata = word_byte(energy_word_c, host_addr[1:0]);
    else if (host_addr == `FEO_FLAGS_A_OFS)
      next_rdata = flags_a; // [RULE4]
    else if (host_addr == `FEO_FLAGS_B_OFS)
      next_rdata = flags_b; // [RULE4]
    else if (host_addr == `FEO_FLAGS_C_OFS)
      next_rdata = flags_c; // [RULE4]
  end

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
    end
    else
    begin
      host_rvalid <= host_rd;
      if (host_rd)
        host_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Phase current linearity correction
  // ----------------------------------------------------------------
  feo_lin_corr #(
    .RMS_W(RMS_W),
    .COEF_W(COEF_W)
  ) u_corr_a (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_valid(rms_valid),
    .low_range(low_range_a),
    .rms(phase_current_rms_a),
    .gain(low_range_gain_coeff_a),
    .offset(low_range_offset_a),
    .corrected(corrected_current_a),
    .out_valid(corrected_valid_a)
  );

  feo_lin_corr #(
    .RMS_W(RMS_W),
    .COEF_W(COEF_W)
  ) u_corr_b (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_valid(rms_valid),
    .low_range(low_range_b),
    .rms(phase_current_rms_b),
    .gain(low_range_gain_coeff_b),
    .offset(low_range_offset_b),
    .corrected(corrected_current_b),
    .out_valid(corrected_valid_b)
  );

  feo_lin_corr #(
    .RMS_W(RMS_W),
    .COEF_W(COEF_W)
  ) u_corr_c (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_valid(rms_valid),
    .low_range(low_range_c),
    .rms(phase_current_rms_c),
    .gain(low_range_gain_coeff_c),
    .offset(low_range_offset_c),
    .corrected(corrected_current_c),
    .out_valid(corrected_valid_c)
  );

endmodule

// file: verif/feo_status_regs_asserts.sv
// Checker for the status bank read port and the phase A correction path.
// Assumes it is bound onto feo_status_regs; every port is on ref_clk.
`include "feo_defines.vh"
module feo_status_regs_asserts #(
  parameter RMS_W = 32
) (
  input wire ref_clk,
  input wire reset,
  input wire [`FEO_ADDR_W-1:0] host_addr,
  input wire host_rd,
  input wire [7:0] host_rdata,
  input wire host_rvalid,
  input wire rms_valid,
  input wire low_range_a,
  input wire [RMS_W-1:0] phase_current_rms_a,
  input wire [RMS_W-1:0] corrected_current_a,
  input wire corrected_valid_a
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Read requests
  // ----------------------------------------
  sequence flag_rd;
    host_rd && (host_addr == `FEO_FLAGS_A_OFS || host_addr == `FEO_FLAGS_B_OFS || host_addr == `FEO_FLAGS_C_OFS);
  endsequence
  sequence top_energy_rd;
    host_rd && (host_addr == `FEO_ENERGY_A_OFS + 10'h3 || host_addr == `FEO_ENERGY_B_OFS + 10'h3
      || host_addr == `FEO_ENERGY_C_OFS + 10'h3);
  endsequence
  sequence unmapped_rd;
    host_rd && host_addr == 10'h200;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_RVALID_AFTER_RD: assert property (host_rd |=> host_rvalid)
    else $error("read strobe got no answer");
  AST_NO_SPURIOUS_RVALID: assert property (!host_rd |=> !host_rvalid)
    else $error("answer without a read strobe");
  AST_RSVD_ZERO: assert property (flag_rd |=> host_rdata[7:5] == 3'h0)
    else $error("reserved flag bits read nonzero");
  AST_ENERGY_MODULUS: assert property (top_energy_rd |=> host_rdata[7:4] == 4'h0)
    else $error("energy above the wrap modulus");
  AST_UNMAPPED_ZERO: assert property (unmapped_rd |=> host_rdata == `FEO_UNMAPPED_DATA)
    else $error("unmapped read not zero");
  // Read data is only allowed to move together with its answer strobe.
  AST_RDATA_HOLDS: assert property (!host_rvalid && !$past(reset) |-> $stable(host_rdata))
    else $error("read data moved without answer");
  AST_CORR_VALID: assert property (rms_valid |=> corrected_valid_a)
    else $error("corrected value not flagged");
  AST_HIGH_RANGE_PASS: assert property (rms_valid && !low_range_a
    |=> corrected_current_a == $past(phase_current_rms_a))
    else $error("high range current altered");
  AST_CORR_HOLDS: assert property (!corrected_valid_a && !$past(reset) |-> $stable(corrected_current_a))
    else $error("corrected current moved");
endmodule

bind feo_status_regs feo_status_regs_asserts #(.RMS_W(RMS_W)) i_asserts (
  .ref_clk, .reset, .host_addr, .host_rd, .host_rdata, .host_rvalid,
  .rms_valid, .low_range_a, .phase_current_rms_a, .corrected_current_a, .corrected_valid_a
);

// file: verif/feo_host_model.sv
// Host controller model: byte reads and writes on the register port.
// Assumes the bench calls its tasks; requests change on the falling edge.
`include "feo_defines.vh"
module feo_host_model (
  input wire ref_clk,
  output logic [`FEO_ADDR_W-1:0] host_addr,
  output logic host_wr,
  output logic [7:0] host_wdata,
  output logic host_rd,
  input wire [7:0] host_rdata,
  input wire host_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd_ok;
  initial
  begin
    host_addr = '0;
    host_wr = 1'b0;
    host_wdata = 8'h00;
    host_rd = 1'b0;
  end
  // Flags are only ever cleared from here, by zeros in the written byte.
  task automatic wr_byte(input logic [`FEO_ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge ref_clk);
    host_wr = 1'b0;
    host_wdata = ~d;
  endtask
  task automatic rd_byte(input logic [`FEO_ADDR_W-1:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge ref_clk);
    host_rd = 1'b0;
    rd_ok = host_rvalid;
    d = host_rdata;
  endtask
  // Wide results are read byte by byte, least significant first.
  task automatic rd_word(input logic [`FEO_ADDR_W-1:0] a, output logic [31:0] w);
    logic [7:0] b;
    for (int i = 0; i < 4; i++)
    begin
      rd_byte(a + `FEO_ADDR_W'(i), b);
      w[8*i +: 8] = b;
    end
  endtask
  function automatic logic [31:0] usage(input logic [31:0] prev, now, input logic wrapped);
    return now - prev + (wrapped ? 32'(`FEO_WRAP_MODULUS) : 32'h0);
  endfunction
endmodule

// file: verif/feo_status_regs_tb_top.sv
// Self-checking bench for the fundamental energy status bank.
// Assumes the host model drives the register port; the bench drives the DSP side.
`include "feo_defines.vh"
module feo_status_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [`FEO_ADDR_W-1:0] host_addr;
  logic host_wr, host_rd, host_rvalid;
  logic [7:0] host_wdata, host_rdata, b;
  logic [3:0] aux_source_select = 4'h0;
  logic aux_rms_valid = 1'b0, energy_strobe = 1'b0, rms_valid = 1'b0;
  logic [31:0] neutral_rms = 32'h12345678, harmonic_rms = 32'h9abcdef0, w, r1;
  logic [15:0] real_pos_incr_a = '0, real_pos_incr_b = '0, real_pos_incr_c = '0;
  logic [3:0] wrap_event_a = '0, wrap_event_b = '0, wrap_event_c = '0;
  logic low_range_a = 1'b0, low_range_b = 1'b0, low_range_c = 1'b0;
  logic [31:0] phase_current_rms_a = '0, phase_current_rms_b = '0, phase_current_rms_c = '0;
  logic [15:0] low_range_gain_coeff_a = '0, low_range_gain_coeff_b = '0, low_range_gain_coeff_c = '0;
  logic [15:0] low_range_offset_a = '0, low_range_offset_b = '0, low_range_offset_c = '0;
  wire [31:0] corrected_current_a, corrected_current_b, corrected_current_c;
  wire corrected_valid_a, corrected_valid_b, corrected_valid_c;
  logic [`FEO_ADDR_W-1:0] fl [3] = '{`FEO_FLAGS_A_OFS, `FEO_FLAGS_B_OFS, `FEO_FLAGS_C_OFS};
  logic [`FEO_ADDR_W-1:0] en [3] = '{`FEO_ENERGY_A_OFS, `FEO_ENERGY_B_OFS, `FEO_ENERGY_C_OFS};
  logic [7:0] exp8 = 8'h00;
  int mismatches = 0;
  int tests_run = 0;

  feo_status_regs i_dut (
    .ref_clk, .reset, .host_addr, .host_wr, .host_wdata, .host_rd, .host_rdata, .host_rvalid,
    .aux_source_select, .aux_rms_valid, .neutral_rms, .harmonic_rms, .energy_strobe,
    .real_pos_incr_a, .real_pos_incr_b, .real_pos_incr_c, .wrap_event_a, .wrap_event_b, .wrap_event_c,
    .rms_valid, .low_range_a, .low_range_b, .low_range_c,
    .phase_current_rms_a, .phase_current_rms_b, .phase_current_rms_c,
    .low_range_gain_coeff_a, .low_range_gain_coeff_b, .low_range_gain_coeff_c,
    .low_range_offset_a, .low_range_offset_b, .low_range_offset_c,
    .corrected_current_a, .corrected_current_b, .corrected_current_c,
    .corrected_valid_a, .corrected_valid_b, .corrected_valid_c
  );
  feo_host_model i_host (.ref_clk, .host_addr, .host_wr, .host_wdata, .host_rd, .host_rdata, .host_rvalid);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd8(input logic [`FEO_ADDR_W-1:0] a, output logic [7:0] d);
    i_host.rd_byte(a, d);
    chk({31'h0, i_host.rd_ok}, 32'h1);
  endtask
  task automatic strobe(input int n);
    @(negedge ref_clk);
    energy_strobe = 1'b1;
    repeat (n) @(negedge ref_clk);
    energy_strobe = 1'b0;
  endtask
  task automatic close_out();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #200us;
    mismatches++;
    $display("[ERR] %0t: watchdog expired", $time);
    close_out();
  end
  initial
  begin
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      rd8(fl[i], b);
      chk(b, `FEO_FLAGS_RESET);
    end
    for (int k = 0; k < 4; k++)
    begin
      @(negedge ref_clk);
      {wrap_event_a, wrap_event_b, wrap_event_c} = {3{4'(1 << k)}};
      @(negedge ref_clk);
      {wrap_event_a, wrap_event_b, wrap_event_c} = 12'h000;
      exp8 = exp8 | 8'(2 << k);
      for (int i = 0; i < 3; i++)
      begin
        rd8(fl[i], b);
        chk(b, exp8);
      end
    end
    i_host.wr_byte(fl[0], 8'hff);
    rd8(fl[0], b);
    chk(b, 8'h1e);
    i_host.wr_byte(fl[0], 8'hfd);
    rd8(fl[0], b);
    chk(b, 8'h1c);
    repeat (50) @(negedge ref_clk);
    rd8(fl[2], b);
    chk(b, 8'h1e);
    for (int i = 0; i < 3; i++)
      i_host.wr_byte(fl[i], 8'h00);
    {real_pos_incr_a, real_pos_incr_b, real_pos_incr_c} = {16'hffff, 16'h0001, 16'h0000};
    strobe(4000);
    i_host.rd_word(en[0], r1);
    chk(r1, 32'(4000 * 65535));
    strobe(97);
    i_host.rd_word(en[0], w);
    chk(w, 32'((4097 * 65535) % `FEO_WRAP_MODULUS));
    rd8(fl[0], b);
    chk(b, 8'h01);
    chk(i_host.usage(r1, w, b[`FEO_REAL_POS_BIT]), 32'(97 * 65535));
    i_host.rd_word(en[1], w);
    chk(w, 32'h1001);
    rd8(fl[1], b);
    chk(b, 8'h00);
    i_host.rd_word(en[2], w);
    chk(w, `FEO_ENERGY_RESET);
    for (int s = 0; s < 2; s++)
    begin
      @(negedge ref_clk);
      aux_source_select = s ? 4'h3 : `FEO_AUX_SEL_NEUTRAL;
      aux_rms_valid = 1'b1;
      @(negedge ref_clk);
      aux_rms_valid = 1'b0;
      i_host.rd_word(`FEO_AUX_RMS_OFS, w);
      chk(w, s ? harmonic_rms : neutral_rms);
    end
    i_host.wr_byte(`FEO_AUX_RMS_OFS, 8'h00);
    i_host.rd_word(`FEO_AUX_RMS_OFS, w);
    chk(w, harmonic_rms);
    i_host.wr_byte(10'h200, 8'h5a);
    rd8(10'h200, b);
    chk(b, `FEO_UNMAPPED_DATA);
    @(negedge ref_clk);
    {low_range_a, low_range_b, low_range_c} = 3'b101;
    {phase_current_rms_a, phase_current_rms_b, phase_current_rms_c} = {32'h3e8, 32'h3e8, 32'h5};
    {low_range_gain_coeff_a, low_range_gain_coeff_b, low_range_gain_coeff_c} = {16'h8000, 16'h8000, 16'h4000};
    {low_range_offset_a, low_range_offset_b, low_range_offset_c} = {16'hfff0, 16'h0100, 16'hff00};
    rms_valid = 1'b1;
    @(negedge ref_clk);
    rms_valid = 1'b0;
    chk({corrected_valid_a, corrected_valid_b, corrected_valid_c}, 32'h7);
    chk(corrected_current_a, (32'h3e8 - 32'h10) * 32'h8000 >> `FEO_GAIN_FRAC_BITS);
    chk(corrected_current_b, 32'h3e8);
    chk(corrected_current_c, 32'h0);
    close_out();
  end
endmodule
